//--- bench/pmac_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

module pmac_cpu_model (
    input wire logic sys_clk,
    output logic ref_valid,
    output logic [15:0] virtual_address,
    output logic [1:0] cur_mode,
    output logic ref_data_space,
    output logic ref_write,
    output logic instr_done,
    output logic trap_ack
);
    // ------------------------------------------------------------
    // Reference issue
    // ------------------------------------------------------------
    initial begin
        {ref_valid, virtual_address, cur_mode, ref_data_space} = '0;
        {ref_write, instr_done, trap_ack} = '0;
    end
    task automatic issue(input logic [1:0] m, input logic ds, input logic w,
            input logic [15:0] va);
        @(posedge sys_clk);
        ref_valid <= 1'b1;
        cur_mode <= m;
        ref_data_space <= ds;
        ref_write <= w;
        virtual_address <= va;
        @(posedge sys_clk);
        ref_valid <= 1'b0;
        virtual_address <= ~va;
        #1;
    endtask
    // Ends the instruction or acknowledges the trap for one cycle.
    task automatic pulse(input logic ack);
        @(posedge sys_clk);
        if (ack) trap_ack <= 1'b1;
        else instr_done <= 1'b1;
        @(posedge sys_clk);
        trap_ack <= 1'b0;
        instr_done <= 1'b0;
        #1;
    endtask
endmodule // pmac_cpu_model
`default_nettype wire

//--- bench/pmac_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmac_defs.vh"

module pmac_top_sva #(
    parameter NUM_PAGES = 48
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_valid,
    input wire logic ref_write,
    input wire logic instr_done,
    input wire logic trap_ack,
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire logic ref_abort,
    input wire logic trap_req
);
    // ------------------------------------------------------------
    // Port checks
    // ------------------------------------------------------------
    localparam int PAGE_END = 256 + NUM_PAGES * 8;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ref_go;
        ref_valid ##1 mem_valid;
    endsequence
    a_ref_answer: assert property (ref_valid |=> mem_valid != ref_abort)
        else $error("reference without a single answer");
    a_idle_quiet: assert property (!ref_valid |=> !mem_valid && !ref_abort)
        else $error("answer without a reference");
    a_write_kind: assert property (s_ref_go |-> mem_write == $past(ref_write))
        else $error("write flag lost");
    a_trap_rise: assert property ($rose(trap_req) |-> $past(instr_done))
        else $error("trap raised before instruction end");
    a_trap_fall: assert property ($fell(trap_req) |-> $past(trap_ack))
        else $error("trap dropped without acknowledge");
    a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready
        && ((s_axi_araddr >= 12'h00C && s_axi_araddr < 12'h100) || s_axi_araddr >= PAGE_END)
        |=> s_axi_rresp == `PMAC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // pmac_top_sva
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmac_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb;
    logic sys_clk, rstn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, cur_mode, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic ref_valid, ref_data_space, ref_write, instr_done, trap_ack;
    logic mem_valid, mem_write, ref_abort, trap_req, ab_r, ab_w, at;
    logic [15:0] virtual_address, base;
    logic [21:0] mem_addr;
    logic [1:0] modes [3];
    int bad_count, samples_checked;

    pmac_top dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_valid,
        .virtual_address, .cur_mode, .ref_data_space, .ref_write, .instr_done,
        .trap_ack, .mem_valid, .mem_write, .mem_addr, .ref_abort, .trap_req);
    pmac_cpu_model cpu (.sys_clk, .ref_valid, .virtual_address, .cur_mode,
        .ref_data_space, .ref_write, .instr_done, .trap_ack);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Register bus master; each ready is held from the request until the answer.
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 64);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 64) begin bad_count++; end_sim; end
    endtask
    task automatic axi_rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 64) begin bad_count++; end_sim; end
    endtask
    task automatic ref_chk(input logic [1:0] m, input logic ds, input logic w,
            input logic [15:0] va, input logic ab, input logic [21:0] pa);
        cpu.issue(m, ds, w, va);
        `CHK(ref_abort, ab);
        `CHK(mem_valid, !ab);
        if (!ab) `CHK(mem_addr, pa);
        if (!ab) `CHK(mem_write, w);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        bad_count = 0;
        samples_checked = 0;
        modes = '{`PMAC_MODE_KERNEL, `PMAC_MODE_SUPER, `PMAC_MODE_USER};
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        axi_rd(`PMAC_OFS_STATUS3);
        `CHK(rdat, 32'h0);
        axi_rd(12'h00C);
        `CHK(rsp, `PMAC_RESP_SLVERR);
        axi_wr(12'h0F0, 32'h1);
        `CHK(rsp, `PMAC_RESP_SLVERR);
        ref_chk(`PMAC_MODE_USER, 1'b1, 1'b1, 16'hE5A7, 1'b0, 22'h00E5A7);
        axi_wr(`PMAC_OFS_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            base = {4'(i + 1), 12'h3C1};
            axi_wr(12'(256 + i * 128), {16'h0, base});
            axi_wr(12'(260 + i * 128), 32'h5);
            ref_chk(modes[i], 1'b1, 1'b0, 16'h1FFF, 1'b0, {base + 16'h7F, 6'h3F});
        end
        ref_chk(2'b10, 1'b0, 1'b0, 16'h0000, 1'b1, 22'h0);
        axi_wr(12'h240, 32'h0ABC);
        axi_wr(12'h244, 32'h5);
        axi_wr(`PMAC_OFS_STATUS3, 32'h1);
        ref_chk(`PMAC_MODE_USER, 1'b1, 1'b0, 16'h1FFF, 1'b0, {16'h0B3B, 6'h3F});
        ref_chk(`PMAC_MODE_USER, 1'b0, 1'b0, 16'h1FFF, 1'b0, {16'h3440, 6'h3F});
        ref_chk(`PMAC_MODE_SUPER, 1'b1, 1'b0, 16'h1FFF, 1'b0, {16'h2440, 6'h3F});
        axi_wr(12'h138, 32'h0200);
        for (int k = 0; k < 8; k++) begin
            axi_wr(12'h13C, {16'h0, 8'h5A, 4'h3, k[0], 3'(k)});
            ab_r = (k == 0 || k == 3 || k >= 6);
            ab_w = !(k == 4 || k == 5);
            at = (k == 1 || k == 4 || k == 5);
            ref_chk(`PMAC_MODE_KERNEL, 1'b0, 1'b0, 16'hE041, ab_r, {16'h0201, 6'h01});
            ref_chk(`PMAC_MODE_KERNEL, 1'b0, 1'b1, 16'hE041, ab_w, {16'h0201, 6'h01});
            axi_rd(12'h13C);
            `CHK(rdat, {16'h0, 8'h5A, at, !ab_w, 2'b00, k[0], 3'(k)});
            `CHK(trap_req, 1'b0);
            cpu.pulse(1'b0);
            `CHK(trap_req, (k == 1 || k == 4));
            cpu.pulse(1'b1);
            `CHK(trap_req, 1'b0);
        end
        axi_wr(12'h13C, 32'h5);
        ref_chk(`PMAC_MODE_KERNEL, 1'b0, 1'b1, 16'hE000, 1'b0, {16'h0200, 6'h00});
        axi_wr(12'h138, 32'h0200);
        axi_rd(12'h13C);
        `CHK(rdat, 32'h5);
        end_sim;
    end

    initial begin
        #100000;
        bad_count++;
        end_sim;
    end
endmodule // tb

bind pmac_top pmac_top_sva #(.NUM_PAGES(NUM_PAGES)) u_sva (.sys_clk, .rstn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ref_valid, .ref_write, .instr_done, .trap_ack, .mem_valid, .mem_write,
    .ref_abort, .trap_req);
`default_nettype wire

//--- inc/pmac_defs.vh
`ifndef PMAC_DEFS_VH
`define PMAC_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define PMAC_OFS_STATUS3 12'h000
`define PMAC_OFS_CTRL 12'h004
`define PMAC_OFS_TRAP 12'h008
`define PMAC_OFS_PAGES 12'h100
`define PMAC_PAGE_SPAN 12'h180
`define PMAC_NUM_PAGES 48

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PMAC_S3_USER_BIT 0
`define PMAC_S3_SUPER_BIT 1
`define PMAC_S3_KERNEL_BIT 2
`define PMAC_CTRL_ENABLE_BIT 0
`define PMAC_TRAP_HELD_BIT 0
`define PMAC_TRAP_REQ_BIT 1
`define PMAC_DESC_DIR_BIT 3
`define PMAC_DESC_WRITTEN_BIT 6
`define PMAC_DESC_ATTN_BIT 7
`define PMAC_DESC_SW_MASK 16'hFF0F

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define PMAC_RST_WORD 16'h0000
`define PMAC_MODE_KERNEL 2'b00
`define PMAC_MODE_SUPER 2'b01
`define PMAC_MODE_USER 2'b11
`define PMAC_KEY_NONRES 3'b000
`define PMAC_KEY_RO_TRAP 3'b001
`define PMAC_KEY_RO 3'b010
`define PMAC_KEY_RW_TRAP 3'b100
`define PMAC_KEY_RW 3'b101
`define PMAC_RESP_OKAY 2'b00
`define PMAC_RESP_SLVERR 2'b10

`endif

//--- rtl/pmac_top.v
// What this block does
// - Three status-three bits choose per mode instruction-only or split instruction/data mapping.
// - Without split mapping for the mode, all references use that mode's instruction set.
// - Each entry is a 16-bit base and 16-bit descriptor; eight per space per mode.
// - The mode's register sets are chosen from status word bits fifteen and fourteen.
// - Mode 00 is kernel, 01 supervisor, 11 user.
// - With mapping on, address bits fifteen to thirteen pick one of eight entries.
// - Fetches, immediates, absolute words and index words are instruction-space references.
// - Operand data and indirect pointers are data-space; register operands make no reference.
// - The base register holds a 16-bit block number of the page start.
// - Address bits twelve to six add to the block number; low six bits append.
// - With mapping off the 16-bit address passes through unchanged.
// - The low three descriptor bits are the access key deciding proceed, trap or abort.
// - Keys 000, 011, 110 and 111 abort every reference.
// - Keys 001 and 010 abort writes; 001 traps reads, 010 reads silently.
// - Key 100 completes reads and writes then traps; key 101 allows both quietly.
// - An aborting reference never completes; a trapping reference completes normally.
// - A management trap is held back until the current instruction finishes.
// - Any reference that modifies an addressable word counts as a write.
// - Descriptor bit three gives the growth direction: zero upward, one downward; this block only stores and reads back the bit.
// - Descriptor bit six is set when the page is written.
// - Software writing the page's base or descriptor clears the written bit.
// - Bit seven is set by key 001 reads, key 100 accesses, key 101 writes.
// - Software writing the page's base or descriptor clears the attention bit.
`timescale 1ns/1ns
`default_nettype none
`include "pmac_defs.vh"

module pmac_top #(
    parameter NUM_PAGES = `PMAC_NUM_PAGES
) (
    input wire sys_clk,
    input wire rstn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ref_valid,
    input wire [15:0] virtual_address,
    input wire [1:0] cur_mode,
    input wire ref_data_space,
    input wire ref_write,
    input wire instr_done,
    input wire trap_ack,
    output reg mem_valid,
    output reg mem_write,
    output reg [21:0] mem_addr,
    output reg ref_abort,
    output reg trap_req
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg [15:0] page_base [0:NUM_PAGES-1];
    reg [15:0] page_descriptor [0:NUM_PAGES-1];
    reg [2:0] mgmt_status_three;
    reg map_enable;
    reg trap_held;

    // ------------------------------------------------------------------------
    // Reference lookup
    // ------------------------------------------------------------------------
    reg [1:0] mode_idx;
    reg mode_ok;
    reg split_on;
    wire use_dspace;
    wire [2:0] page_select_field;
    wire [6:0] block_index;
    wire [5:0] byte_in_block;
    wire [5:0] ref_idx;
    wire [15:0] sel_base;
    wire [15:0] sel_desc;
    wire [2:0] access_key;
    wire [15:0] page_base_block;
    wire [15:0] phys_block;
    reg key_abort;
    reg key_trap;
    wire hit_ok;
    wire set_written;
    wire set_attn;

    always @* begin
        mode_ok = 1'b1;
        mode_idx = 2'd0;
        split_on = 1'b0;
        case (cur_mode)
            `PMAC_MODE_KERNEL: begin
                mode_idx = 2'd0;
                split_on = mgmt_status_three[`PMAC_S3_KERNEL_BIT];
            end
            `PMAC_MODE_SUPER: begin
                mode_idx = 2'd1;
                split_on = mgmt_status_three[`PMAC_S3_SUPER_BIT];
            end
            `PMAC_MODE_USER: begin
                mode_idx = 2'd2;
                split_on = mgmt_status_three[`PMAC_S3_USER_BIT];
            end
            default: begin
                mode_ok = 1'b0;
            end
        endcase
    end

    // The core classifies each reference (fetch, immediate, absolute, index
    // words as instruction; operands and indirect pointers as data) and raises
    // no request at all for register operands.
    assign use_dspace = ref_data_space & split_on;
    assign page_select_field = virtual_address[15:13];
    assign block_index = virtual_address[12:6];
    assign byte_in_block = virtual_address[5:0];
    assign ref_idx = {mode_idx, use_dspace, page_select_field};
    assign sel_base = page_base[ref_idx];
    assign sel_desc = page_descriptor[ref_idx];
    assign access_key = sel_desc[2:0];
    assign page_base_block = sel_base;
    assign phys_block = page_base_block + {9'h000, block_index};

    // A write here means any store or read-modify-write of a word.
    always @* begin
        key_abort = 1'b1;
        key_trap = 1'b0;
        case (access_key)
            `PMAC_KEY_RO_TRAP: begin
                key_abort = ref_write;
                key_trap = ~ref_write;
            end
            `PMAC_KEY_RO: begin
                key_abort = ref_write;
                key_trap = 1'b0;
            end
            `PMAC_KEY_RW_TRAP: begin
                key_abort = 1'b0;
                key_trap = 1'b1;
            end
            `PMAC_KEY_RW: begin
                key_abort = 1'b0;
                key_trap = 1'b0;
            end
            default: begin
                key_abort = 1'b1;
                key_trap = 1'b0;
            end
        endcase
    end

    assign hit_ok = ref_valid & map_enable & mode_ok & ~key_abort;
    assign set_written = hit_ok & ref_write;
    assign set_attn = hit_ok & (key_trap | (access_key == `PMAC_KEY_RW & ref_write));

    // ------------------------------------------------------------------------
    // Memory request stage
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_valid <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 22'h000000;
            ref_abort <= 1'b0;
        end else begin
            mem_write <= ref_write;
            if (!map_enable) begin
                mem_valid <= ref_valid;
                mem_addr <= {6'h00, virtual_address};
                ref_abort <= 1'b0;
            end else begin
                mem_valid <= hit_ok;
                mem_addr <= {phys_block, byte_in_block};
                ref_abort <= ref_valid & (key_abort | ~mode_ok);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Deferred trap
    // ------------------------------------------------------------------------
    wire new_trap;
    assign new_trap = hit_ok & key_trap;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            trap_held <= 1'b0;
            trap_req <= 1'b0;
        end else begin
            if (instr_done) begin
                trap_held <= 1'b0;
            end else if (new_trap) begin
                trap_held <= 1'b1;
            end
            if (instr_done & (trap_held | new_trap)) begin
                trap_req <= 1'b1;
            end else if (trap_ack) begin
                trap_req <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------------
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire do_write;
    wire [11:0] wr_off;
    wire wr_page;
    wire [5:0] wr_idx;
    wire wr_desc;
    wire [15:0] wr_mask;
    wire wr_known;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign wr_off = aw_addr - `PMAC_OFS_PAGES;
    assign wr_page = (aw_addr >= `PMAC_OFS_PAGES) & (wr_off < `PMAC_PAGE_SPAN);
    assign wr_idx = wr_off[8:3];
    assign wr_desc = wr_off[2];
    assign wr_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wr_known = wr_page | aw_addr == `PMAC_OFS_STATUS3 | aw_addr == `PMAC_OFS_CTRL
        | aw_addr == `PMAC_OFS_TRAP;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMAC_RESP_OKAY;
            mgmt_status_three <= 3'h0;
            map_enable <= 1'b0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `PMAC_RESP_OKAY : `PMAC_RESP_SLVERR;
                if (aw_addr == `PMAC_OFS_STATUS3 && w_strb[0]) begin
                    mgmt_status_three <= w_data[2:0];
                end
                if (aw_addr == `PMAC_OFS_CTRL && w_strb[0]) begin
                    map_enable <= w_data[`PMAC_CTRL_ENABLE_BIT];
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Page entries
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PAGES; gi = gi + 1) begin : g_page
            wire sw_hit;
            wire hw_hit;
            assign sw_hit = do_write & wr_page & (wr_idx == gi);
            assign hw_hit = ref_idx == gi;
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    page_base[gi] <= `PMAC_RST_WORD;
                    page_descriptor[gi] <= `PMAC_RST_WORD;
                end else begin
                    if (sw_hit & ~wr_desc) begin
                        page_base[gi] <= (page_base[gi] & ~wr_mask)
                            | (w_data[15:0] & wr_mask);
                    end
                    if (sw_hit & wr_desc) begin
                        page_descriptor[gi][15:8] <= w_strb[1] ? w_data[15:8]
                            : page_descriptor[gi][15:8];
                        page_descriptor[gi][3:0] <= w_strb[0] ? w_data[3:0]
                            : page_descriptor[gi][3:0];
                    end
                    // A hardware set in the same cycle wins over the clear.
                    if (hw_hit & set_written) begin
                        page_descriptor[gi][`PMAC_DESC_WRITTEN_BIT] <= 1'b1;
                    end else if (sw_hit) begin
                        page_descriptor[gi][`PMAC_DESC_WRITTEN_BIT] <= 1'b0;
                    end
                    if (hw_hit & set_attn) begin
                        page_descriptor[gi][`PMAC_DESC_ATTN_BIT] <= 1'b1;
                    end else if (sw_hit) begin
                        page_descriptor[gi][`PMAC_DESC_ATTN_BIT] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------------
    wire [11:0] rd_addr;
    wire [11:0] rd_off;
    wire rd_page;
    wire [5:0] rd_idx;
    reg [31:0] next_rdata;
    reg next_rerr;

    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_addr = {s_axi_araddr[11:2], 2'b00};
    assign rd_off = rd_addr - `PMAC_OFS_PAGES;
    assign rd_page = (rd_addr >= `PMAC_OFS_PAGES) & (rd_off < `PMAC_PAGE_SPAN);
    assign rd_idx = rd_off[8:3];

    always @* begin
        next_rdata = 32'h00000000;
        next_rerr = 1'b0;
        if (rd_page) begin
            next_rdata[15:0] = rd_off[2] ? (page_descriptor[rd_idx] & `PMAC_DESC_SW_MASK
                | page_descriptor[rd_idx] & 16'h00C0) : page_base[rd_idx];
        end else if (rd_addr == `PMAC_OFS_STATUS3) begin
            next_rdata[2:0] = mgmt_status_three;
        end else if (rd_addr == `PMAC_OFS_CTRL) begin
            next_rdata[`PMAC_CTRL_ENABLE_BIT] = map_enable;
        end else if (rd_addr == `PMAC_OFS_TRAP) begin
            next_rdata[`PMAC_TRAP_HELD_BIT] = trap_held;
            next_rdata[`PMAC_TRAP_REQ_BIT] = trap_req;
        end else begin
            next_rerr = 1'b1;
        end
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMAC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rerr ? `PMAC_RESP_SLVERR : `PMAC_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pmac_top
`default_nettype wire
